// ==== rtl/ppfm_fall_det.sv ====
// Purpose: Falling-edge detector on one pin, sampled on the machine-cycle enable.
// Assumes: Pin input synchronous to the clock.
// Notes:   A fall is reported as one clock pulse in the clock cycle after the low sample.
module ppfm_fall_det
(
	input  wire logic i_sys_clk,
	input  wire logic i_arst_n,
	input  wire logic i_mc_en,
	input  wire logic i_pin,
	output logic      o_fall
);
	import ppfm_pkg::*;

	typedef struct packed {
		logic prev;
		logic fall;
	} ppfm_fd_s;

	ppfm_fd_s st_ff;
	ppfm_fd_s nxt_st;

	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.fall = 1'b0;
		if (i_mc_en)
		begin
			nxt_st.fall = st_ff.prev & ~i_pin;
			nxt_st.prev = i_pin;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			st_ff <= '{prev: 1'b1, fall: 1'b0};
		else
			st_ff <= nxt_st;
	end

	assign o_fall = st_ff.fall;
endmodule // ppfm_fall_det

// ==== rtl/ppfm_pkg.sv ====
// Purpose: Shared constants and carriers for the port pin function mux.
// Assumes: One 250 MHz clock; machine-cycle enable generated inside the block.
// Notes:   Pin indices, timing constants, the latch reset value and signal structs; no software-visible registers.
package ppfm_pkg;
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned MC_PERIOD_NS     = 48;
	localparam int unsigned MC_DIV           = (MC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_MIN_MC       = 2;
	localparam int unsigned PORT_W           = 8;
	localparam logic [7:0]  LATCH_RESET      = 8'hFF;
	localparam int unsigned P1_EVT           = 0;
	localparam int unsigned P1_CAP           = 1;
	localparam int unsigned P1_SCL           = 6;
	localparam int unsigned P1_SDA           = 7;
	localparam int unsigned P3_RXD           = 0;
	localparam int unsigned P3_TXD           = 1;
	localparam int unsigned P3_IRQ0          = 2;
	localparam int unsigned P3_IRQ1          = 3;
	localparam int unsigned P3_CNT0          = 4;
	localparam int unsigned P3_CNT1          = 5;
	localparam int unsigned P3_WRS           = 6;
	localparam int unsigned P3_RDS           = 7;

	typedef struct packed {
		logic       rxd_out;
		logic       rxd_oe;
		logic       txd;
		logic       wr_strobe;
		logic       rd_strobe;
		logic       scl_out;
		logic       sda_out;
	} ppfm_alt_out_s;

	typedef struct packed {
		logic       timer2_event_input;
		logic       timer2_capture_reload_trigger;
		logic       external_irq_zero_gate;
		logic       external_irq_one_gate;
		logic       timer_zero_count_input;
		logic       timer_one_count_input;
		logic       rxd_in;
		logic       scl_in;
		logic       sda_in;
	} ppfm_alt_in_s;
endpackage

// ==== rtl/ppfm_top.sv ====
// Purpose: Port 1 / port 3 pin structure, alternate functions and reset pin.
// Assumes: Pins resolved outside; port o_*_oe_n low means this block drives low strongly, o_rst_pin_oe_n low drives it high.
// Notes:   o_*_pu marks the weak pull-up; the wire resolves it below any external low.
module ppfm_top
(
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_arst_n,
	input  wire logic [7:0]              i_p1_latch,
	input  wire logic [7:0]              i_p3_latch,
	input  wire logic [7:0]              i_p1_pin,
	input  wire logic [7:0]              i_p3_pin,
	output logic      [7:0]              o_p1_out,
	output logic      [7:0]              o_p1_oe_n,
	output logic      [7:0]              o_p1_pu,
	output logic      [7:0]              o_p3_out,
	output logic      [7:0]              o_p3_oe_n,
	output logic      [7:0]              o_p3_pu,
	output logic      [7:0]              o_p1_read,
	output logic      [7:0]              o_p3_read,
	input  wire ppfm_pkg::ppfm_alt_out_s i_alt,
	input  wire logic                    i_serial_sync_mode,
	output ppfm_pkg::ppfm_alt_in_s       o_alt,
	output logic                         o_timer2_event_fall,
	output logic                         o_timer2_trigger_fall,
	input  wire logic                    i_rst_pin,
	input  wire logic                    i_watchdog_overflow_unit,
	output logic                         o_rst_pin_out,
	output logic                         o_rst_pin_oe_n,
	output logic                         o_internal_reset
);
	import ppfm_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [3:0] div;
		logic       mc_en;
		logic [1:0] rst_cnt;
		logic       ext_rst;
		logic       wdt_rst;
		logic [3:0] wdt_cnt;
		logic [7:0] p1_out;
		logic [7:0] p3_out;
	} ppfm_st_s;

	ppfm_st_s st_ff;
	ppfm_st_s nxt_st;
	logic [7:0] p3_eff;

	// ****************************************************************
	// Port 3 effective output
	// ****************************************************************
	// An alternate output can only pull low when the latch is one; a zero latch wins.
	always_comb
	begin
		p3_eff         = i_p3_latch;
		p3_eff[P3_RXD] = i_p3_latch[P3_RXD] &
			(~(i_serial_sync_mode & i_alt.rxd_oe) | i_alt.rxd_out);
		p3_eff[P3_TXD] = i_p3_latch[P3_TXD] & i_alt.txd;
		p3_eff[P3_WRS] = i_p3_latch[P3_WRS] & i_alt.wr_strobe;
		p3_eff[P3_RDS] = i_p3_latch[P3_RDS] & i_alt.rd_strobe;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.mc_en = 1'b0;
		if (st_ff.div == 4'(MC_DIV - 1))
		begin
			nxt_st.div   = 4'h0;
			nxt_st.mc_en = 1'b1;
		end
		else
			nxt_st.div = st_ff.div + 4'h1;
		if (st_ff.mc_en)
		begin
			// Shorter highs are ignored so a glitch cannot reset the core.
			if (!i_rst_pin)
			begin
				nxt_st.rst_cnt = 2'h0;
				nxt_st.ext_rst = 1'b0;
			end
			else if (st_ff.rst_cnt == 2'(RST_MIN_MC - 1))
				nxt_st.ext_rst = 1'b1;
			else
				nxt_st.rst_cnt = st_ff.rst_cnt + 2'h1;
			if (st_ff.wdt_rst)
			begin
				if (st_ff.wdt_cnt == 4'hF)
					nxt_st.wdt_rst = 1'b0;
				else
					nxt_st.wdt_cnt = st_ff.wdt_cnt + 4'h1;
			end
		end
		if (i_watchdog_overflow_unit)
		begin
			nxt_st.wdt_rst = 1'b1;
			nxt_st.wdt_cnt = 4'h0;
		end
		nxt_st.p1_out         = i_p1_latch;
		nxt_st.p1_out[P1_SCL] = i_p1_latch[P1_SCL] & i_alt.scl_out;
		nxt_st.p1_out[P1_SDA] = i_p1_latch[P1_SDA] & i_alt.sda_out;
		nxt_st.p3_out         = p3_eff;
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			st_ff <= '{div: 4'h0, mc_en: 1'b0, rst_cnt: 2'h0, ext_rst: 1'b0,
				wdt_rst: 1'b0, wdt_cnt: 4'h0, p1_out: LATCH_RESET, p3_out: LATCH_RESET};
		else
			st_ff <= nxt_st;
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	// A port pin one is never driven strongly, so board drivers may pull the pin low.
	assign o_p1_out  = 8'h00;
	assign o_p1_oe_n = st_ff.p1_out;
	assign o_p1_pu   = st_ff.p1_out & 8'h3F;
	assign o_p3_out  = 8'h00;
	assign o_p3_oe_n = st_ff.p3_out;
	assign o_p3_pu   = st_ff.p3_out;
	assign o_p1_read = i_p1_pin;
	assign o_p3_read = i_p3_pin;

	assign o_internal_reset = st_ff.ext_rst | st_ff.wdt_rst;
	assign o_rst_pin_out    = 1'b1;
	assign o_rst_pin_oe_n   = ~st_ff.wdt_rst;

	// ****************************************************************
	// Alternate inputs
	// ****************************************************************
	always_comb
	begin
		o_alt                               = '0;
		o_alt.timer2_event_input            = i_p1_pin[P1_EVT];
		o_alt.timer2_capture_reload_trigger = i_p1_pin[P1_CAP];
		o_alt.scl_in                        = i_p1_pin[P1_SCL];
		o_alt.sda_in                        = i_p1_pin[P1_SDA];
		o_alt.rxd_in                        = i_p3_pin[P3_RXD];
		o_alt.external_irq_zero_gate        = i_p3_pin[P3_IRQ0];
		o_alt.external_irq_one_gate         = i_p3_pin[P3_IRQ1];
		o_alt.timer_zero_count_input        = i_p3_pin[P3_CNT0];
		o_alt.timer_one_count_input         = i_p3_pin[P3_CNT1];
	end

	ppfm_fall_det u_evt_fall
	(
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_mc_en   (st_ff.mc_en),
		.i_pin     (i_p1_pin[P1_EVT]),
		.o_fall    (o_timer2_event_fall)
	);

	ppfm_fall_det u_cap_fall
	(
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_mc_en   (st_ff.mc_en),
		.i_pin     (i_p1_pin[P1_CAP]),
		.o_fall    (o_timer2_trigger_fall)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	open_drain_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!o_p1_pu[P1_SCL] && !o_p1_pu[P1_SDA])
		else $error("open drain pulled up");
	scl_drive_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(i_p1_latch[P1_SCL]) |-> o_p1_oe_n[P1_SCL] == $past(i_alt.scl_out))
		else $error("bus clock drive mismatch");
	sda_drive_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(i_p1_latch[P1_SDA]) |-> o_p1_oe_n[P1_SDA] == $past(i_alt.sda_out))
		else $error("bus data drive mismatch");
	zero_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		!$past(i_p3_latch[P3_WRS]) |-> !o_p3_oe_n[P3_WRS])
		else $error("latch zero not low");
	wr_strobe_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(i_p3_latch[P3_WRS]) |-> o_p3_oe_n[P3_WRS] == $past(i_alt.wr_strobe))
		else $error("write strobe mismatch");
	txd_drive_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(i_p3_latch[P3_TXD]) |-> o_p3_oe_n[P3_TXD] == $past(i_alt.txd))
		else $error("transmit mismatch");
	p1_weak_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_p1_oe_n == $past(i_p1_latch) || $past(i_alt.scl_out & i_alt.sda_out) == 1'b0)
		else $error("port 1 drive mismatch");
	// Pins with no alternate output must show a pull-up exactly where the latch holds one.
	p3_pullup_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_p3_pu == o_p3_oe_n &&
		o_p3_pu[P3_CNT1:P3_IRQ0] == $past(i_p3_latch[P3_CNT1:P3_IRQ0]))
		else $error("port 3 pull-up missing");
	wdt_pin_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		i_watchdog_overflow_unit |=> !o_rst_pin_oe_n && o_internal_reset)
		else $error("watchdog reset pin");
	// The pin is only judged at machine-cycle samples, so a reset must follow two high
	// samples one machine cycle apart; a low between two samples is not seen.
	short_rst_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		$rose(st_ff.ext_rst) |-> $past(i_rst_pin) && $past(i_rst_pin, MC_DIV + 1))
		else $error("short reset accepted");
	evt_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_timer2_event_fall |-> !$past(i_p1_pin[P1_EVT]))
		else $error("event not falling");
	trig_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_timer2_trigger_fall |-> !$past(i_p1_pin[P1_CAP]))
		else $error("trigger not falling");
endmodule // ppfm_top

// ==== sim/ppfm_board.sv ====
// Purpose: Board circuitry around the port 1, port 3 and reset pins.
// Assumes: The two-wire bus has pull-ups on the board for port 1 pins six and seven.
// Notes:   A released pin with no pull-up shows the inverse of its last level.
module ppfm_board
(
	input  wire logic       i_sys_clk,
	input  wire logic [7:0] i_p1_out,
	input  wire logic [7:0] i_p1_oe_n,
	input  wire logic [7:0] i_p1_pu,
	input  wire logic [7:0] i_p3_out,
	input  wire logic [7:0] i_p3_oe_n,
	input  wire logic [7:0] i_p3_pu,
	input  wire logic [7:0] i_p1_low,
	input  wire logic [7:0] i_p3_low,
	input  wire logic       i_rst_out,
	input  wire logic       i_rst_oe_n,
	input  wire logic       i_rst_hold,
	output logic      [7:0] o_p1_pin,
	output logic      [7:0] o_p3_pin,
	output logic            o_rst_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] p1_last_ff;
	logic [7:0] p3_last_ff;
	logic [7:0] p1_low;
	logic [7:0] p3_low;
	assign p1_low = (~i_p1_oe_n & ~i_p1_out) | i_p1_low;
	assign p3_low = (~i_p3_oe_n & ~i_p3_out) | i_p3_low;
	assign o_p1_pin = ~p1_low & (i_p1_pu | 8'hC0 | ~p1_last_ff);
	assign o_p3_pin = ~p3_low & (i_p3_pu | ~p3_last_ff);
	// The pin has a pull-down, so only a driver can make it high.
	assign o_rst_pin = i_rst_hold | (~i_rst_oe_n & i_rst_out);
	always @(posedge i_sys_clk)
	begin
		p1_last_ff <= o_p1_pin;
		p3_last_ff <= o_p3_pin;
	end
endmodule // ppfm_board

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the port pin function mux.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Peripheral outputs idle released; the serial data pin idles as input.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ppfm_pkg::*;
	logic          clk = 1'b0;
	logic          arst_n = 1'b0;
	logic [7:0]    l1, l3, pin1, pin3, low1, low3, out1, oe1, pu1, out3, oe3, pu3, rd1, rd3;
	ppfm_alt_out_s alt;
	ppfm_alt_in_s  alt_in;
	logic          sync, evf, trf, rpin, wdt, rout, roe_n, irst, rhold;
	int            bad_count = 0;
	int            num_checks = 0;
	int            cycles = 0;
	int            ne, nt;
	int unsigned   in_bit [9] = '{P1_EVT, P1_CAP, P3_IRQ0, P3_IRQ1, P3_CNT0, P3_CNT1, P3_RXD,
		P1_SCL, P1_SDA};
	always #2 clk = ~clk;
	ppfm_top u_dut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_p1_latch(l1), .i_p3_latch(l3),
		.i_p1_pin(pin1), .i_p3_pin(pin3), .o_p1_out(out1), .o_p1_oe_n(oe1), .o_p1_pu(pu1),
		.o_p3_out(out3), .o_p3_oe_n(oe3), .o_p3_pu(pu3), .o_p1_read(rd1), .o_p3_read(rd3),
		.i_alt(alt), .i_serial_sync_mode(sync), .o_alt(alt_in), .o_timer2_event_fall(evf),
		.o_timer2_trigger_fall(trf), .i_rst_pin(rpin), .i_watchdog_overflow_unit(wdt),
		.o_rst_pin_out(rout), .o_rst_pin_oe_n(roe_n), .o_internal_reset(irst));
	ppfm_board u_board (.i_sys_clk(clk), .i_p1_out(out1), .i_p1_oe_n(oe1), .i_p1_pu(pu1),
		.i_p3_out(out3), .i_p3_oe_n(oe3), .i_p3_pu(pu3), .i_p1_low(low1), .i_p3_low(low3),
		.i_rst_out(rout), .i_rst_oe_n(roe_n), .i_rst_hold(rhold), .o_p1_pin(pin1),
		.o_p3_pin(pin3), .o_rst_pin(rpin));
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task alt_case(input logic [6:0] a, input logic s, input logic [7:0] e1, e3);
		alt = a;
		sync = s;
		step(2);
		chk("p1_oe_n", e1, oe1);
		chk("p3_oe_n", e3, oe3);
	endtask
	task pulses(input int n);
		ne = 0;
		nt = 0;
		repeat (n)
		begin
			step(1);
			ne += int'(evf !== 1'b0);
			nt += int'(trf !== 1'b0);
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_quasi;
		l1 = 8'h5A;
		low1 = 8'h02;
		l3 = 8'hC3;
		low3 = 8'h80;
		step(2);
		chk("p1_oe_n", 8'h5A, oe1);
		chk("p1_read", 8'h58, rd1);
		chk("p1_pu_od", 0, pu1[7:6]);
		chk("p1_out", 0, out1);
		chk("p3_out", 0, out3);
		chk("p3_pu", 8'hC3, pu3);
		chk("p3_read", 8'h43, rd3);
		{l1, l3, low1, low3} = {16'hFFFF, 16'h0};
		step(2);
	endtask
	task t_alt_in;
		for (int i = 0; i < 9; i++)
		begin
			low1 = (i inside {[2:6]}) ? 8'h00 : 8'h01 << in_bit[i];
			low3 = (i inside {[2:6]}) ? 8'h01 << in_bit[i] : 8'h00;
			step(1);
			chk("alt_in", ~(9'h100 >> i), alt_in);
		end
		{low1, low3} = 16'h0;
	endtask
	task t_falls;
		for (int k = 0; k < 2; k++)
		begin
			step(30);
			low1 = 8'h01 << k;
			pulses(40);
			chk("event_falls", 9'(k == 0), 9'(ne));
			chk("trigger_falls", 9'(k == 1), 9'(nt));
			low1 = 8'h00;
			pulses(30);
			chk("rise_pulses", 0, 9'(ne + nt));
		end
	endtask
	task t_reset_pin;
		rhold = 1'b1;
		step(11);
		rhold = 1'b0;
		ne = 0;
		repeat (50)
		begin
			step(1);
			ne += int'(irst !== 1'b0);
		end
		chk("short_reset", 0, 9'(ne));
		rhold = 1'b1;
		step(40);
		chk("long_reset", 1, irst);
		rhold = 1'b0;
		step(40);
		chk("reset_end", 0, irst);
	endtask
	task t_watchdog;
		wdt = 1'b1;
		step(1);
		wdt = 1'b0;
		chk("wdt_drive", 2'b10, {rout, roe_n});
		chk("wdt_reset", 1, irst);
		step(150);
		chk("wdt_pin", 2'b11, {rpin, irst});
		step(120);
		chk("wdt_release", 1, roe_n);
		step(40);
		chk("wdt_reset_end", 0, irst);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			summarize();
		end
	end
	initial
	begin
		{l1, l3, low1, low3, alt, sync, wdt, rhold} = {16'hFFFF, 16'h0, 7'h5F, 3'b000};
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		step(1);
		chk("p1_pu", 8'h3F, pu1);
		chk("p3_pu", 8'hFF, pu3);
		t_quasi();
		alt_case(7'h4F, 0, 8'hFF, 8'hFD);
		alt_case(7'h57, 0, 8'hFF, 8'hBF);
		alt_case(7'h5B, 0, 8'hFF, 8'h7F);
		alt_case(7'h5D, 0, 8'hBF, 8'hFF);
		alt_case(7'h5E, 0, 8'h7F, 8'hFF);
		alt_case(7'h3F, 1, 8'hFF, 8'hFE);
		alt_case(7'h3F, 0, 8'hFF, 8'hFF);
		l3 = 8'hBF;
		alt_case(7'h5F, 0, 8'hFF, 8'hBF);
		l3 = 8'hFF;
		step(2);
		t_alt_in();
		t_falls();
		t_reset_pin();
		t_watchdog();
		summarize();
	end
endmodule // tb
